// >>> task_switch_state_unit.sv
// task selector register, task switch sequencer and task gate checks
// assumes a word memory port with a one-cycle ack and a core register file
// reachable by word index; all inputs are on clk_sys
`timescale 1ns/1ps

// How it works
// (R1) a switch saves the outgoing state words, then loads the incoming ones
// (R2) jump or call naming a task state block or task gate starts a switch
// (R3) selector register changes only by load op; read back only by store op (the code also loads it at the commit of a jump or call switch)
// (R4) any selector access outside protected mode faults
// (R5) load op faults unless current privilege is zero
// (R6) load op selector must index the global descriptor table
// (R7) only the 16-bit selector is visible; base, limit, rights stay inside
// (R8) both 32-bit and 16-bit block layouts are saved and restored
// (R9) a gate switch is judged by the gate's descriptor privilege
// (R10) requested and current privilege must both be below gate privilege
// (R11) requested-privilege bits inside the gate selector are ignored
// (R12) bitmap pointer comes from upper half of word +64h
// (R13) back link lives in low half of word +0h
// (R14) local table selector saved and restored at word +60h
// (R15) selector slots written with zero upper halves
// (R16) failed gate check faults and leaves the selector register alone
module task_switch_state_unit (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // request from the core
   input wire logic req_valid,
   output logic req_ready,
   input task_switch_pkg::op_kind_type req_kind,
   input wire logic [15:0] req_selector,
   input wire logic req_via_gate,
   input wire logic [31:0] gate_word_lo,
   input wire logic [31:0] gate_word_hi,
   input wire logic prot_mode,
   input wire logic [1:0] current_privilege,
   input wire logic [31:0] global_table_base,
   // answer
   output logic done_pulse,
   output logic fault_pulse,
   output logic [15:0] store_sel_out,
   output logic [15:0] task_selector_register,
   output logic [15:0] iomap_base,
   // core register file
   output logic [4:0] ctx_rd_idx,
   output logic ctx_fmt32,
   input wire logic [31:0] ctx_rd_data,
   output logic ctx_wr_en,
   output logic [4:0] ctx_wr_idx,
   output logic [31:0] ctx_wr_data,
   // memory port
   output logic mem_req,
   output logic mem_we,
   output logic mem_half,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);

   // ************************************************************
   // state
   // ************************************************************
   task_switch_pkg::state_type state_r;
   logic is_call_r, is_load_r;
   logic [15:0] sel_r, new_sel_r;
   logic [31:0] base_r, new_base_r, desc_lo_r;
   logic fmt32_r, new_fmt32_r;
   logic [4:0] idx_r;
   logic [31:0] save_word;
   logic [31:0] acc_base;
   logic acc_fmt32;
   logic [15:0] gate_target;
   logic gate_ok;
   logic [3:0] desc_type;
   logic desc_ok;
   logic sel_slot;
   logic [4:0] last_idx;

   // gate target: its requested-privilege bits are dropped on purpose
   assign gate_target = {gate_word_lo[31:18], 2'b00}; // see (R11)
   // strict compare, so a gate at privilege zero can never be entered
   assign gate_ok = (gate_word_hi[task_switch_pkg::TYPE_LSB +: 4] == task_switch_pkg::TYPE_TASK_GATE)
                    && (req_selector[1:0] < gate_word_hi[task_switch_pkg::PRIV_LSB +: 2]) // see (R9)
                    && (current_privilege < gate_word_hi[task_switch_pkg::PRIV_LSB +: 2]); // see (R10)
   assign desc_type = mem_rdata[task_switch_pkg::TYPE_LSB +: 4];
   assign desc_ok = mem_rdata[task_switch_pkg::PRESENT_BIT]
                    && (desc_type == task_switch_pkg::TYPE_TSB32_FREE
                        || desc_type == task_switch_pkg::TYPE_TSB16_FREE); // see (R2)

   // which block and layout the current walk step touches
   assign acc_base = (state_r == task_switch_pkg::ST_SAVE) ? base_r : new_base_r;
   assign acc_fmt32 = (state_r == task_switch_pkg::ST_SAVE) ? fmt32_r : new_fmt32_r;
   assign last_idx = acc_fmt32 ? task_switch_pkg::W32_LAST_IDX : task_switch_pkg::W16_LAST_IDX; // see (R8)
   // selector slots of the 32-bit layout: ss0..ss2 and es..ldt
   assign sel_slot = (idx_r == 5'h02) || (idx_r == 5'h04) || (idx_r == 5'h06) || (idx_r >= 5'h12);
   always_comb begin
      save_word = ctx_rd_data;
      if (!fmt32_r) begin
         save_word = {16'h0000, ctx_rd_data[15:0]};
      end else if (sel_slot) begin
         save_word = {16'h0000, ctx_rd_data[15:0]}; // see (R15)
      end
   end

   // ************************************************************
   // memory and register-file drive
   // ************************************************************
   // memory request is a level held until ack
   always_comb begin
      mem_req = 1'b0;
      mem_we = 1'b0;
      mem_half = 1'b0;
      mem_addr = 32'h0000_0000;
      mem_wdata = 32'h0000_0000;
      unique case (state_r)
         task_switch_pkg::ST_DESC_LO: begin
            mem_req = 1'b1;
            mem_addr = global_table_base + {16'h0000, new_sel_r[15:3], 3'b000}; // see (R6)
         end
         task_switch_pkg::ST_DESC_HI: begin
            mem_req = 1'b1;
            mem_addr = global_table_base + {16'h0000, new_sel_r[15:3], 3'b100};
         end
         task_switch_pkg::ST_SAVE, task_switch_pkg::ST_LOAD: begin
            mem_req = 1'b1;
            mem_we = (state_r == task_switch_pkg::ST_SAVE); // see (R1)
            mem_half = !acc_fmt32; // see (R8)
            mem_addr = acc_fmt32 ? acc_base + {25'h0, idx_r, 2'b00} : acc_base + {26'h0, idx_r, 1'b0}; // see (R14)
            mem_wdata = save_word;
         end
         task_switch_pkg::ST_LINK: begin
            mem_req = 1'b1;
            mem_we = 1'b1;
            mem_half = !new_fmt32_r;
            mem_addr = new_base_r + {24'h0, task_switch_pkg::OFF_BACK_LINK};
            mem_wdata = {16'h0000, sel_r}; // see (R13)
         end
         task_switch_pkg::ST_IOMAP: begin
            mem_req = 1'b1;
            mem_addr = new_base_r + {24'h0, task_switch_pkg::OFF_IOMAP}; // see (R12)
         end
         default: begin
            mem_req = 1'b0;
         end
      endcase
   end

   assign req_ready = (state_r == task_switch_pkg::ST_IDLE);
   assign ctx_rd_idx = idx_r;
   assign ctx_fmt32 = acc_fmt32;
   // only the selector leaves the block; base and limit stay hidden
   assign task_selector_register = sel_r; // see (R7)

   // ************************************************************
   // sequencer
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= task_switch_pkg::ST_IDLE;
         idx_r <= 5'h00;
         is_call_r <= 1'b0;
         is_load_r <= 1'b0;
         new_sel_r <= task_switch_pkg::RST_SEL;
         new_base_r <= task_switch_pkg::RST_BASE;
         new_fmt32_r <= 1'b1;
         desc_lo_r <= 32'h0000_0000;
         done_pulse <= 1'b0;
         fault_pulse <= 1'b0;
         store_sel_out <= task_switch_pkg::RST_SEL;
      end else begin
         done_pulse <= 1'b0;
         fault_pulse <= 1'b0;
         unique case (state_r)
            task_switch_pkg::ST_IDLE: begin
               if (req_valid) begin
                  is_call_r <= (req_kind == task_switch_pkg::OP_CALL);
                  is_load_r <= (req_kind == task_switch_pkg::OP_LOAD_SEL);
                  new_sel_r <= (req_via_gate && req_kind != task_switch_pkg::OP_LOAD_SEL) ? gate_target : req_selector;
                  if (!prot_mode) begin
                     fault_pulse <= 1'b1; // see (R4)
                  end else if (req_kind == task_switch_pkg::OP_STORE_SEL) begin
                     store_sel_out <= sel_r; // see (R3)
                     done_pulse <= 1'b1;
                  end else if (req_kind == task_switch_pkg::OP_LOAD_SEL) begin
                     if (current_privilege != 2'b00 || req_selector[task_switch_pkg::SEL_TABLE_BIT]) begin
                        fault_pulse <= 1'b1; // see (R5) see (R6)
                     end else begin
                        state_r <= task_switch_pkg::ST_DESC_LO;
                     end
                  end else if (req_via_gate && !gate_ok) begin
                     fault_pulse <= 1'b1; // see (R16)
                  end else if (!req_via_gate && req_selector[task_switch_pkg::SEL_TABLE_BIT]) begin
                     fault_pulse <= 1'b1;
                  end else begin
                     state_r <= task_switch_pkg::ST_DESC_LO; // see (R2)
                  end
               end
            end
            task_switch_pkg::ST_DESC_LO: begin
               if (mem_ack) begin
                  desc_lo_r <= mem_rdata;
                  state_r <= task_switch_pkg::ST_DESC_HI;
               end
            end
            task_switch_pkg::ST_DESC_HI: begin
               if (mem_ack) begin
                  new_base_r <= {mem_rdata[31:24], mem_rdata[7:0], desc_lo_r[31:16]};
                  new_fmt32_r <= (desc_type == task_switch_pkg::TYPE_TSB32_FREE);
                  idx_r <= task_switch_pkg::FIRST_STATE_IDX;
                  if (!desc_ok) begin
                     fault_pulse <= 1'b1;
                     state_r <= task_switch_pkg::ST_IDLE;
                  end else if (is_load_r) begin
                     state_r <= task_switch_pkg::ST_COMMIT;
                  end else begin
                     state_r <= task_switch_pkg::ST_SAVE;
                  end
               end
            end
            task_switch_pkg::ST_SAVE: begin
               if (mem_ack) begin
                  if (idx_r == last_idx) begin
                     idx_r <= task_switch_pkg::FIRST_STATE_IDX;
                     state_r <= task_switch_pkg::ST_LOAD; // see (R1)
                  end else begin
                     idx_r <= idx_r + 5'h01;
                  end
               end
            end
            task_switch_pkg::ST_LOAD: begin
               if (mem_ack) begin
                  if (idx_r == last_idx) begin
                     if (is_call_r) begin
                        state_r <= task_switch_pkg::ST_LINK;
                     end else if (new_fmt32_r) begin
                        state_r <= task_switch_pkg::ST_IOMAP;
                     end else begin
                        state_r <= task_switch_pkg::ST_COMMIT;
                     end
                  end else begin
                     idx_r <= idx_r + 5'h01;
                  end
               end
            end
            task_switch_pkg::ST_LINK: begin
               if (mem_ack) begin
                  state_r <= new_fmt32_r ? task_switch_pkg::ST_IOMAP : task_switch_pkg::ST_COMMIT;
               end
            end
            task_switch_pkg::ST_IOMAP: begin
               if (mem_ack) begin
                  state_r <= task_switch_pkg::ST_COMMIT;
               end
            end
            task_switch_pkg::ST_COMMIT: begin
               done_pulse <= 1'b1;
               state_r <= task_switch_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // restored words go to the core one cycle after their ack
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctx_wr_en <= 1'b0;
         ctx_wr_idx <= 5'h00;
         ctx_wr_data <= 32'h0000_0000;
      end else begin
         ctx_wr_en <= (state_r == task_switch_pkg::ST_LOAD) && mem_ack;
         ctx_wr_idx <= idx_r;
         ctx_wr_data <= new_fmt32_r ? mem_rdata : {16'h0000, mem_rdata[15:0]}; // see (R8)
      end
   end

   // hidden cached part and visible selector, swapped at commit; iomap_base is taken at the bitmap pointer read
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sel_r <= task_switch_pkg::RST_SEL;
         base_r <= task_switch_pkg::RST_BASE;
         fmt32_r <= 1'b1;
         iomap_base <= task_switch_pkg::RST_IOMAP;
      end else begin
         if (state_r == task_switch_pkg::ST_IOMAP && mem_ack) begin
            iomap_base <= mem_rdata[31:16]; // see (R12)
         end
         if (state_r == task_switch_pkg::ST_COMMIT) begin
            sel_r <= new_sel_r; // see (R3)
            base_r <= new_base_r;
            fmt32_r <= new_fmt32_r;
            if (!new_fmt32_r) begin
               iomap_base <= task_switch_pkg::RST_IOMAP;
            end
         end
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   logic idle_req;
   assign idle_req = req_ready && req_valid;

   AST_REAL_MODE_FAULT: assert property (idle_req && !prot_mode |=> fault_pulse && !done_pulse) // see (R4)
      else $error("access outside protected mode not refused");
   AST_LOAD_RING0: assert property (idle_req && prot_mode && req_kind == task_switch_pkg::OP_LOAD_SEL
      && current_privilege != 2'b00 |=> fault_pulse ##1 $stable(sel_r)) // see (R5)
      else $error("load at nonzero privilege not refused");
   AST_LOAD_GLOBAL_ONLY: assert property (idle_req && prot_mode && req_kind == task_switch_pkg::OP_LOAD_SEL
      && req_selector[2] |=> fault_pulse && req_ready) // see (R6)
      else $error("load from local table not refused");
   AST_STORE_READBACK: assert property (idle_req && prot_mode && req_kind == task_switch_pkg::OP_STORE_SEL
      |=> done_pulse && store_sel_out == $past(sel_r)) // see (R3)
      else $error("store op returned wrong selector");
   AST_SEL_CHANGE_CAUSE: assert property (!$stable(sel_r) |-> $past(state_r) == task_switch_pkg::ST_COMMIT) // see (R3)
      else $error("selector changed outside commit");
   AST_GATE_REFUSED: assert property (idle_req && prot_mode && req_via_gate && req_kind[1] && !gate_ok
      |=> fault_pulse && req_ready ##1 $stable(sel_r)) // see (R16)
      else $error("failed gate check not refused");
   AST_SLOT_UPPER_ZERO: assert property (state_r == task_switch_pkg::ST_SAVE && fmt32_r && sel_slot
      |-> mem_wdata[31:16] == 16'h0000) // see (R15)
      else $error("selector slot upper half not zero");
   AST_SAVE_THEN_LOAD: assert property ($rose(state_r == task_switch_pkg::ST_LOAD)
      |-> $past(state_r) == task_switch_pkg::ST_SAVE && $past(mem_ack)) // see (R1)
      else $error("load phase began without finished save");
   AST_LINK_WORD: assert property (state_r == task_switch_pkg::ST_LINK
      |-> mem_addr == new_base_r && mem_we && mem_wdata[15:0] == sel_r) // see (R13)
      else $error("back link written wrong");
   AST_LDT_OFFSET: assert property (state_r == task_switch_pkg::ST_LOAD && new_fmt32_r
      && idx_r == task_switch_pkg::W32_LAST_IDX |-> mem_addr == new_base_r + {24'h0, task_switch_pkg::OFF_LOCAL_SEL}) // see (R14)
      else $error("local table slot not at +60h");
   AST_IOMAP_UPPER: assert property (state_r == task_switch_pkg::ST_IOMAP && mem_ack
      |=> iomap_base == $past(mem_rdata[31:16])) // see (R12)
      else $error("bitmap pointer not taken from upper half");
   AST_HALF_LAYOUT: assert property (state_r == task_switch_pkg::ST_SAVE && !fmt32_r |-> mem_half) // see (R8)
      else $error("16-bit layout not written as halves");

   COV_LOAD_DONE: cover property (is_load_r && state_r == task_switch_pkg::ST_COMMIT);
   COV_CALL_DONE: cover property (is_call_r && state_r == task_switch_pkg::ST_LINK ##[1:4] done_pulse);
   COV_GATE_FAULT: cover property (idle_req && req_via_gate && !gate_ok ##1 fault_pulse);

endmodule

// >>> task_switch_pkg.sv
// constants and types for the task-switch state unit
// assumes a single core clock domain; shared by the design file and the bench
package task_switch_pkg;

   // ************************************************************
   // task state block layout (byte offsets and word indices)
   // ************************************************************
   localparam logic [7:0] OFF_BACK_LINK = 8'h00;
   localparam logic [7:0] OFF_LOCAL_SEL = 8'h60;
   localparam logic [7:0] OFF_IOMAP = 8'h64;
   localparam logic [7:0] OFF_IOMAP_USUAL = 8'h68; // bitmap often starts here
   localparam logic [4:0] W32_LAST_IDX = 5'h18; // ldt slot, word 0x60
   localparam logic [4:0] W16_LAST_IDX = 5'h15; // ldt slot of the 16-bit layout
   localparam logic [4:0] FIRST_STATE_IDX = 5'h01;

   // ************************************************************
   // descriptor fields (high word) and the selector table bit
   // ************************************************************
   localparam int TYPE_LSB = 8;
   localparam int PRIV_LSB = 13;
   localparam int PRESENT_BIT = 15;
   localparam int SEL_TABLE_BIT = 2; // 1 = local table
   localparam logic [3:0] TYPE_TSB16_FREE = 4'h1;
   localparam logic [3:0] TYPE_TASK_GATE = 4'h5;
   localparam logic [3:0] TYPE_TSB32_FREE = 4'h9;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [15:0] RST_SEL = 16'h0000;
   localparam logic [31:0] RST_BASE = 32'h0000_0000;
   localparam logic [15:0] RST_IOMAP = 16'h0000;

   typedef enum logic [1:0] {
      OP_LOAD_SEL = 2'b00,
      OP_STORE_SEL = 2'b01,
      OP_JUMP = 2'b10,
      OP_CALL = 2'b11
   } op_kind_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DESC_LO = 3'b001,
      ST_DESC_HI = 3'b010,
      ST_SAVE = 3'b011,
      ST_LOAD = 3'b100,
      ST_LINK = 3'b101,
      ST_IOMAP = 3'b110,
      ST_COMMIT = 3'b111
   } state_type;

endpackage

// >>> tb_top.sv
// self-checking bench for the task switch state unit
// assumes the design package is compiled first; the bench plays core, register file and memory
`timescale 1ns/1ps

module tb_top;

   // ************************************************************
   // stimulus, responses and logs
   // ************************************************************
   typedef struct {logic [31:0] a; logic [31:0] d; logic h; logic [4:0] x;} wr_type;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_via_gate = 1'b0;
   logic prot_mode = 1'b1;
   logic mem_ack = 1'b0;
   logic slow = 1'b0;
   logic tog = 1'b0;
   task_switch_pkg::op_kind_type req_kind = task_switch_pkg::OP_STORE_SEL;
   logic [15:0] req_selector = 16'h0000;
   logic [31:0] gate_word_lo = 32'h0000_0000;
   logic [31:0] gate_word_hi = 32'h0000_0000;
   logic [1:0] current_privilege = 2'h0;
   logic [31:0] global_table_base = 32'h0000_1000;
   logic [31:0] mem_rdata = 32'h0000_0000;
   logic [31:0] ctx_rd_data;
   logic req_ready, done_pulse, fault_pulse, ctx_fmt32, ctx_wr_en, mem_req, mem_we, mem_half;
   logic [15:0] store_sel_out, task_selector_register, iomap_base;
   logic [4:0] ctx_rd_idx, ctx_wr_idx;
   logic [31:0] ctx_wr_data, mem_addr, mem_wdata;
   logic [31:0] mem [logic [31:0]];
   wr_type wlog[$];
   logic [4:0] xlog[$];
   logic [31:0] clog[$];
   int num_errors = 0;
   int checked = 0;

   task_switch_state_unit uut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
      .req_kind(req_kind), .req_selector(req_selector), .req_via_gate(req_via_gate),
      .gate_word_lo(gate_word_lo), .gate_word_hi(gate_word_hi), .prot_mode(prot_mode),
      .current_privilege(current_privilege), .global_table_base(global_table_base),
      .done_pulse(done_pulse), .fault_pulse(fault_pulse), .store_sel_out(store_sel_out),
      .task_selector_register(task_selector_register), .iomap_base(iomap_base),
      .ctx_rd_idx(ctx_rd_idx), .ctx_fmt32(ctx_fmt32), .ctx_rd_data(ctx_rd_data),
      .ctx_wr_en(ctx_wr_en), .ctx_wr_idx(ctx_wr_idx), .ctx_wr_data(ctx_wr_data),
      .mem_req(mem_req), .mem_we(mem_we), .mem_half(mem_half), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata)
   );

   always #2 clk_sys = ~clk_sys;

   function automatic logic [31:0] ctxv(input logic [4:0] x);
      return {11'h3f1, x, 11'h2a5, x};
   endfunction

   // untouched words read back as an address pattern so a stale bus never looks right
   function automatic logic [31:0] rd(input logic [31:0] a);
      if (mem.exists(a)) return mem[a];
      return {~a[15:0], a[15:0]};
   endfunction

   function automatic logic [31:0] dhi(input logic [31:0] b, input logic [3:0] t);
      return {b[31:24], 8'h00, 4'h8, t, b[23:16]};
   endfunction

   assign ctx_rd_data = ctxv(ctx_rd_idx);

   // memory answers at the falling edge; slow mode acks every other cycle
   always @(negedge clk_sys) begin
      tog <= ~tog;
      mem_ack <= mem_req && (!slow || tog);
      mem_rdata <= rd(mem_addr);
      if (mem_req === 1'b1 && mem_we === 1'b1 && (!slow || tog)) begin
         wlog.push_back('{mem_addr, mem_wdata, mem_half, ctx_rd_idx});
         mem[mem_addr] = mem_wdata;
      end
      if (ctx_wr_en === 1'b1) begin
         xlog.push_back(ctx_wr_idx);
         clog.push_back(ctx_wr_data);
      end
   end

   // ************************************************************
   // checking and closing
   // ************************************************************
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d, comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   // one request from a falling edge; returns cycles from take to done or fault
   task automatic run_op(input task_switch_pkg::op_kind_type k, input logic [15:0] s, input logic v,
                         input logic [31:0] lo, input logic [31:0] hi, output int cyc, output logic flt);
      int n;
      // let an edge pass so no strobe is raised in the step that dropped it
      @(negedge clk_sys);
      wlog.delete();
      xlog.delete();
      clog.delete();
      req_kind = k;
      req_selector = s;
      req_via_gate = v;
      gate_word_lo = lo;
      gate_word_hi = hi;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      chk_flag(req_ready, 1'b1);
      @(negedge clk_sys);
      req_valid = 1'b0;
      cyc = 1;
      while (done_pulse !== 1'b1 && fault_pulse !== 1'b1 && cyc < 2000) begin
         @(negedge clk_sys);
         cyc++;
      end
      chk_flag(cyc < 2000, 1'b1);
      flt = fault_pulse;
   endtask

   task automatic t_store(input logic [15:0] exp);
      int c;
      logic f;
      run_op(task_switch_pkg::OP_STORE_SEL, 16'h0000, 1'b0, 32'h0, 32'h0, c, f);
      chk_val(c, 32'h1);
      chk_flag(f, 1'b0);
      chk_val(store_sel_out, exp);
   endtask

   // refused requests: answer next cycle when quick is set, no memory writes, selector kept
   task automatic t_refuse(input task_switch_pkg::op_kind_type k, input logic [15:0] s, input logic v,
                           input logic [31:0] hi, input logic pm, input logic [1:0] cp, input logic quick);
      int c;
      logic f;
      logic [15:0] old;
      old = task_selector_register;
      prot_mode = pm;
      current_privilege = cp;
      run_op(k, s, v, 32'h002b_0000, hi, c, f);
      chk_flag(f, 1'b1);
      if (quick) chk_val(c, 32'h1);
      chk_val(wlog.size(), 32'h0);
      chk_val(task_selector_register, old);
      prot_mode = 1'b1;
      current_privilege = 2'h0;
      @(negedge clk_sys);
   endtask

   task automatic t_load(input logic [15:0] s);
      int c;
      logic f;
      run_op(task_switch_pkg::OP_LOAD_SEL, s, 1'b0, 32'h0, 32'h0, c, f);
      chk_flag(f, 1'b0);
      chk_val(task_selector_register, s);
   endtask

   // full switch: save walk, restore walk, optional back link, bitmap pointer
   task automatic t_switch(input task_switch_pkg::op_kind_type k, input logic [15:0] s, input logic v,
                           input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] ob,
                           input logic o32, input logic [31:0] nb, input logic n32, input logic [15:0] es);
      int c, no, nn;
      logic f;
      logic [15:0] old;
      logic [31:0] e, g;
      old = task_selector_register;
      no = o32 ? 24 : 21;
      nn = n32 ? 24 : 21;
      run_op(k, s, v, lo, hi, c, f);
      chk_flag(f, 1'b0);
      chk_val(wlog.size(), no + (k == task_switch_pkg::OP_CALL));
      for (int i = 1; i <= no && i <= wlog.size(); i++) begin
         e = ctxv(i[4:0]);
         if (!o32 || i == 2 || i == 4 || i == 6 || i >= 18) e[31:16] = 16'h0000;
         g = wlog[i-1].h ? {16'h0000, wlog[i-1].d[15:0]} : wlog[i-1].d;
         chk_flag(wlog[i-1].h, !o32);
         chk_val(wlog[i-1].a, ob + (o32 ? 4 : 2) * i);
         chk_val(g, e);
      end
      if (k == task_switch_pkg::OP_CALL && wlog.size() > no) begin
         chk_val(wlog[no].a, nb);
         chk_val(wlog[no].d[15:0], old);
      end
      chk_val(xlog.size(), nn);
      for (int i = 1; i <= nn && i <= xlog.size(); i++) begin
         e = rd(nb + (n32 ? 4 : 2) * i);
         if (!n32) e[31:16] = 16'h0000;
         chk_val(xlog[i-1], i);
         chk_val(clog[i-1], e);
      end
      chk_val(iomap_base, n32 ? rd(nb + 32'h64) >> 16 : 32'h0);
      chk_val(task_selector_register, es);
      chk_flag(ctx_fmt32, n32);
   endtask

   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      mem[32'h1018] = 32'h2000_00ff;
      mem[32'h101c] = dhi(32'h0000_2000, 4'h9);
      mem[32'h1020] = 32'h3000_00ff;
      mem[32'h1024] = dhi(32'h0000_3000, 4'h9);
      mem[32'h1028] = 32'h4000_00ff;
      mem[32'h102c] = dhi(32'h0000_4000, 4'h1);
      mem[32'h3064] = 32'h0068_0000;
      for (int i = 18; i <= 24; i++) mem[32'h3000 + 4 * i] = 32'h0000_00a0 + i;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      chk_flag(req_ready, 1'b1);
      chk_val(task_selector_register, 16'h0000);
      t_store(16'h0000);
      t_refuse(task_switch_pkg::OP_LOAD_SEL, 16'h0018, 1'b0, 32'h0, 1'b0, 2'h0, 1'b1);
      t_refuse(task_switch_pkg::OP_STORE_SEL, 16'h0000, 1'b0, 32'h0, 1'b0, 2'h0, 1'b1);
      t_refuse(task_switch_pkg::OP_LOAD_SEL, 16'h0018, 1'b0, 32'h0, 1'b1, 2'h1, 1'b1);
      t_refuse(task_switch_pkg::OP_LOAD_SEL, 16'h001c, 1'b0, 32'h0, 1'b1, 2'h0, 1'b1);
      t_load(16'h0018);
      t_store(16'h0018);
      t_refuse(task_switch_pkg::OP_CALL, 16'h0040, 1'b1, 32'h0000_c500, 1'b1, 2'h2, 1'b0);
      t_refuse(task_switch_pkg::OP_JUMP, 16'h0042, 1'b1, 32'h0000_c500, 1'b1, 2'h0, 1'b0);
      t_refuse(task_switch_pkg::OP_CALL, 16'h0040, 1'b1, 32'h0000_e400, 1'b1, 2'h0, 1'b0);
      t_refuse(task_switch_pkg::OP_JUMP, 16'h0024, 1'b0, 32'h0, 1'b1, 2'h0, 1'b0);
      t_refuse(task_switch_pkg::OP_JUMP, 16'h0030, 1'b0, 32'h0, 1'b1, 2'h0, 1'b0);
      t_switch(task_switch_pkg::OP_JUMP, 16'h0020, 1'b0, 32'h0, 32'h0,
               32'h2000, 1'b1, 32'h3000, 1'b1, 16'h0020);
      slow = 1'b1;
      t_switch(task_switch_pkg::OP_CALL, 16'h0041, 1'b1, 32'h002b_0000, 32'h0000_e500,
               32'h3000, 1'b1, 32'h4000, 1'b0, 16'h0028);
      slow = 1'b0;
      t_switch(task_switch_pkg::OP_JUMP, 16'h0020, 1'b0, 32'h0, 32'h0,
               32'h4000, 1'b0, 32'h3000, 1'b1, 16'h0020);
      t_store(16'h0020);
      report_and_stop();
   end

   // the whole sequence needs well under a thousand cycles per switch
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      report_and_stop();
   end

endmodule
